// ---- include/tbcs_pkg.sv ----
package tbcs_pkg;
   localparam logic [4:0]  REG_RSVD_A      = 5'h15;
   localparam logic [4:0]  REG_LEGACY      = 5'h16;
   localparam int          BIT_LINK_DIS    = 15;
   localparam int          BIT_JAB_DIS     = 14;
   localparam int          BIT_ECHO_DIS    = 13;
   localparam int          BIT_SQE_DIS     = 12;
   localparam int          BIT_SQL_HI      = 11;
   localparam int          BIT_SQL_LO      = 10;
   localparam int          BIT_STICKY_EN   = 9;
   localparam int          BIT_EOF_ERR     = 8;
   localparam int          BIT_DISC        = 7;
   localparam int          BIT_LINK_UP     = 6;
   localparam int          BIT_CRS_HI      = 2;
   localparam int          BIT_CRS_LO      = 1;
   localparam logic [15:0] RSVD_A_RESET    = 16'h0000;
   localparam logic        LINK_DIS_RESET  = 1'b0;
   localparam logic        JAB_DIS_RESET   = 1'b0;
   localparam logic [1:0]  SQL_RESET       = 2'h0;
   localparam logic        STICKY_EN_RESET = 1'b1;
   localparam logic [1:0]  CRS_CTL_RESET   = 2'h0;
   localparam logic [1:0]  SQL_NORMAL      = 2'h0;
   localparam logic [1:0]  SQL_LOW         = 2'h1;
   localparam logic [1:0]  SQL_HIGH        = 2'h2;
   localparam logic [1:0]  SPEED_10        = 2'h0;
   localparam logic [1:0]  SPEED_100       = 2'h1;
   localparam logic [1:0]  SPEED_1000      = 2'h2;
   // clock rate and timing
   localparam int          CLK_HZ          = 10_000_000;
   localparam int          JAB_TIME_MS     = 20;
   localparam int          JAB_CYCLES      = JAB_TIME_MS * (CLK_HZ / 1000);
   localparam int          SQE_TIME_NS     = 1000;
   localparam int          SQE_CYCLES_I    = (SQE_TIME_NS * (CLK_HZ / 1_000_000)) / 1000;
   localparam logic [3:0]  SQE_CYCLES      = SQE_CYCLES_I[3:0];
   typedef enum logic [1:0] {
      JB_IDLE = 2'h0,
      JB_TX   = 2'h1,
      JB_CUT  = 2'h3
   } tbcs_jab_t;
endpackage

// ---- include/tbcs_crs_if.sv ----
`timescale 1ns/100ps
interface tbcs_crs_if;
   logic [1:0] crs_ctl;
   logic       half_duplex;
   logic       rx_dv;
   logic       tx_en;
   logic       crs;
   modport ctl (output crs_ctl, output half_duplex, output rx_dv, output tx_en, input crs);
   modport mux (input crs_ctl, input half_duplex, input rx_dv, input tx_en, output crs);
endinterface

// ---- logic/tbcs_crs_mux.sv ----
`timescale 1ns/100ps
module tbcs_crs_mux (
   input  wire logic  core_clk_i,
   input  wire logic  rst_i,
   tbcs_crs_if.mux    crs_bus
);
   import tbcs_pkg::*;

   typedef struct packed {
      logic crs;
   } tbcs_crs_st_t;

   tbcs_crs_st_t st;
   tbcs_crs_st_t next_st;

   always_comb begin
      next_st = st;
      if (crs_bus.half_duplex) begin
         if (crs_bus.crs_ctl[1] == 1'b0) begin
            next_st.crs = crs_bus.rx_dv | crs_bus.tx_en;
         end else begin
            next_st.crs = crs_bus.rx_dv;
         end
      end else begin
         if (crs_bus.crs_ctl[0] == 1'b0) begin
            next_st.crs = crs_bus.rx_dv;
         end else begin
            next_st.crs = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign crs_bus.crs = st.crs;
endmodule

// ---- logic/tbcs_ctrl.sv ----
`timescale 1ns/100ps
module tbcs_ctrl #(
   parameter int JAB_LIMIT = tbcs_pkg::JAB_CYCLES
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_i,
   input  wire logic        soft_rst_i,
   input  wire logic [1:0]  hardware_config_straps_i,
   // decoded management access
   input  wire logic [4:0]  mgmt_addr_i,
   input  wire logic        mgmt_wr_i,
   input  wire logic        mgmt_rd_i,
   input  wire logic [15:0] mgmt_wdata_i,
   output logic      [15:0] mgmt_rdata_o,
   output logic             mgmt_rvalid_o,
   // line state
   input  wire logic [1:0]  speed_i,
   input  wire logic        half_duplex_operation_i,
   input  wire logic        link_integrity_ok_i,
   input  wire logic        eof_error_evt_i,
   input  wire logic        disconnect_evt_i,
   // mac side
   input  wire logic        tx_en_i,
   input  wire logic [3:0]  txd_i,
   input  wire logic        rx_dv_i,
   input  wire logic [3:0]  rxd_i,
   output logic             rx_dv_o,
   output logic      [3:0]  rxd_o,
   output logic             crs_o,
   output logic             tx_enable_o,
   output logic             collision_heartbeat_pulse_o,
   output logic             link_pass_o,
   output logic             link_integrity_bypass_o,
   output logic      [1:0]  squelch_sel_o
);
   import tbcs_pkg::*;

   typedef struct packed {
      logic        strap_done;
      logic        echo_dflt;
      logic        sqe_dflt;
      logic        link_dis;
      logic        jab_dis;
      logic        echo_dis;
      logic        sqe_dis;
      logic [1:0]  sql;
      logic        sticky_en;
      logic        eof_err;
      logic        disc;
      logic [1:0]  crs_ctl;
      logic [15:0] rdata;
      logic        rvalid;
      tbcs_jab_t   jab;
      logic [31:0] jab_cnt;
      logic        tx_en_d;
      logic [3:0]  sqe_cnt;
      logic        hb;
      logic        rx_dv;
      logic [3:0]  rxd;
      logic        tx_out;
      logic        link_pass;
      logic        bypass;
      logic [1:0]  sql_out;
   } tbcs_st_t;

   tbcs_st_t st;
   tbcs_st_t next_st;
   logic     ten_hdx;
   logic     link_up;
   logic     rd_hit;
   logic     crs_q;

   tbcs_crs_if crs_bus ();

   tbcs_crs_mux u_crs (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .crs_bus    (crs_bus)
   );

   assign crs_bus.crs_ctl     = st.crs_ctl;
   assign crs_bus.half_duplex = half_duplex_operation_i;
   assign crs_bus.rx_dv       = rx_dv_i;
   assign crs_bus.tx_en       = tx_en_i;
   assign crs_q               = crs_bus.crs;

   assign ten_hdx = (speed_i == SPEED_10) && half_duplex_operation_i;
   assign link_up = st.link_dis | link_integrity_ok_i;
   assign rd_hit  = mgmt_rd_i && (mgmt_addr_i == REG_LEGACY);

   always_comb begin
      next_st        = st;
      next_st.rvalid = 1'b0;

      // strap capture on the first edge after release
      if (!st.strap_done) begin
         next_st.strap_done = 1'b1;
         next_st.echo_dflt  = hardware_config_straps_i[0];
         next_st.sqe_dflt   = hardware_config_straps_i[1];
         next_st.echo_dis   = hardware_config_straps_i[0];
         next_st.sqe_dis    = hardware_config_straps_i[1];
      end

      // register read, reserved space reads zero
      if (mgmt_rd_i) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = RSVD_A_RESET;
         if (mgmt_addr_i == REG_LEGACY) begin
            next_st.rdata[BIT_LINK_DIS]          = st.link_dis;
            next_st.rdata[BIT_JAB_DIS]           = st.jab_dis;
            next_st.rdata[BIT_ECHO_DIS]          = st.echo_dis;
            next_st.rdata[BIT_SQE_DIS]           = st.sqe_dis;
            next_st.rdata[BIT_SQL_HI:BIT_SQL_LO] = st.sql;
            next_st.rdata[BIT_STICKY_EN]         = st.sticky_en;
            next_st.rdata[BIT_EOF_ERR]           = st.eof_err;
            next_st.rdata[BIT_DISC]              = st.disc;
            next_st.rdata[BIT_LINK_UP]           = link_up;
            next_st.rdata[BIT_CRS_HI:BIT_CRS_LO] = st.crs_ctl;
         end
      end

      // read-clear flags; a new event in the same cycle wins
      if (rd_hit) begin
         next_st.eof_err = 1'b0;
         next_st.disc    = 1'b0;
      end

      // writes touch only the writable fields
      if (mgmt_wr_i && (mgmt_addr_i == REG_LEGACY)) begin
         next_st.link_dis  = mgmt_wdata_i[BIT_LINK_DIS];
         next_st.jab_dis   = mgmt_wdata_i[BIT_JAB_DIS];
         next_st.echo_dis  = mgmt_wdata_i[BIT_ECHO_DIS];
         next_st.sqe_dis   = mgmt_wdata_i[BIT_SQE_DIS];
         next_st.sql       = mgmt_wdata_i[BIT_SQL_HI:BIT_SQL_LO];
         next_st.sticky_en = mgmt_wdata_i[BIT_STICKY_EN];
         next_st.crs_ctl   = mgmt_wdata_i[BIT_CRS_HI:BIT_CRS_LO];
      end

      // software reset
      if (soft_rst_i) begin
         next_st.eof_err = 1'b0;
         next_st.disc    = 1'b0;
         if (!st.sticky_en) begin
            next_st.link_dis = LINK_DIS_RESET;
            next_st.jab_dis  = JAB_DIS_RESET;
            next_st.echo_dis = st.echo_dflt;
            next_st.sqe_dis  = st.sqe_dflt;
            next_st.sql      = SQL_RESET;
            next_st.crs_ctl  = CRS_CTL_RESET;
         end
         next_st.sticky_en = st.sticky_en;
      end

      if (eof_error_evt_i) begin
         next_st.eof_err = 1'b1;
      end
      if (disconnect_evt_i) begin
         next_st.disc = 1'b1;
      end

      // jabber watchdog on the transmit request
      case (st.jab)
         JB_IDLE: begin
            next_st.jab_cnt = '0;
            if (tx_en_i) begin
               next_st.jab = JB_TX;
            end
         end
         JB_TX: begin
            next_st.jab_cnt = st.jab_cnt + 32'h1;
            if (!tx_en_i) begin
               next_st.jab = JB_IDLE;
            end else if (!st.jab_dis && (st.jab_cnt >= JAB_LIMIT - 1)) begin
               next_st.jab = JB_CUT;
            end
         end
         JB_CUT: begin
            next_st.jab_cnt = '0;
            if (!tx_en_i || st.jab_dis) begin
               next_st.jab = JB_IDLE;
            end
         end
         default: begin
            next_st.jab = JB_IDLE;
         end
      endcase
      next_st.tx_out = tx_en_i && (next_st.jab != JB_CUT);

      // heartbeat after each transmit in 10BASE-T half duplex
      next_st.tx_en_d = tx_en_i;
      if (st.sqe_cnt != 4'h0) begin
         next_st.sqe_cnt = st.sqe_cnt - 4'h1;
      end else if (st.tx_en_d && !tx_en_i && ten_hdx && !st.sqe_dis) begin
         next_st.sqe_cnt = SQE_CYCLES;
      end
      next_st.hb = (next_st.sqe_cnt != 4'h0) && ten_hdx && !st.sqe_dis;

      // receive path with transmit echo
      if (ten_hdx && !st.echo_dis && tx_en_i) begin
         next_st.rx_dv = 1'b1;
         next_st.rxd   = txd_i;
      end else begin
         next_st.rx_dv = rx_dv_i;
         next_st.rxd   = rxd_i;
      end

      next_st.link_pass = link_up;
      next_st.bypass    = st.link_dis;
      case (st.sql)
         SQL_LOW:  next_st.sql_out = SQL_LOW;
         SQL_HIGH: next_st.sql_out = SQL_HIGH;
         default:  next_st.sql_out = SQL_NORMAL;
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st           <= '0;
         st.sticky_en <= STICKY_EN_RESET;
         st.jab       <= JB_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign mgmt_rdata_o                = st.rdata;
   assign mgmt_rvalid_o               = st.rvalid;
   assign rx_dv_o                     = st.rx_dv;
   assign rxd_o                       = st.rxd;
   assign crs_o                       = crs_q;
   assign tx_enable_o                 = st.tx_out;
   assign collision_heartbeat_pulse_o = st.hb;
   assign link_pass_o                 = st.link_pass;
   assign link_integrity_bypass_o     = st.bypass;
   assign squelch_sel_o               = st.sql_out;
endmodule

// ---- sim/tbcs_ctrl_chk.sv ----
`timescale 1ns/100ps
module tbcs_ctrl_chk (
   input wire logic        core_clk_i,
   input wire logic        rst_i,
   input wire logic [4:0]  mgmt_addr_i,
   input wire logic        mgmt_rd_i,
   input wire logic [15:0] mgmt_rdata_o,
   input wire logic        mgmt_rvalid_o,
   input wire logic        link_integrity_ok_i,
   input wire logic        half_duplex_operation_i,
   input wire logic [1:0]  speed_i,
   input wire logic        tx_en_i,
   input wire logic        rx_dv_i,
   input wire logic        rx_dv_o,
   input wire logic        crs_o,
   input wire logic        tx_enable_o,
   input wire logic        collision_heartbeat_pulse_o,
   input wire logic        link_pass_o,
   input wire logic        link_integrity_bypass_o,
   input wire logic [1:0]  squelch_sel_o
);
   import tbcs_pkg::*;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   rvalid_timing_a: assert property (!$past(rst_i) |-> mgmt_rvalid_o == $past(mgmt_rd_i))
      else $error("read valid not one cycle after read");
   rsvd_bits_a: assert property (mgmt_rvalid_o |-> mgmt_rdata_o[5:3] == 3'h0 && !mgmt_rdata_o[0])
      else $error("reserved bits not zero");
   rsvd_reg_a: assert property (mgmt_rvalid_o && $past(mgmt_addr_i) != REG_LEGACY |-> mgmt_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   link_live_a: assert property (mgmt_rvalid_o && $past(mgmt_addr_i) == REG_LEGACY
      && $past(link_integrity_ok_i) |-> mgmt_rdata_o[6])
      else $error("link status bit not live");
   link_pass_a: assert property (!$past(rst_i)
      |-> link_pass_o == (link_integrity_bypass_o | $past(link_integrity_ok_i)))
      else $error("link pass wrong");
   crs_rx_a: assert property (!$past(rst_i) && $past(half_duplex_operation_i && rx_dv_i) |-> crs_o)
      else $error("half duplex carrier sense missed");
   crs_idle_a: assert property (!$past(rx_dv_i || tx_en_i) |-> !crs_o)
      else $error("carrier sense without cause");
   jab_gate_a: assert property (tx_enable_o |-> $past(tx_en_i))
      else $error("transmit enable without request");
   sql_code_a: assert property (squelch_sel_o != 2'h3)
      else $error("reserved squelch code driven");
   hb_len_a: assert property ($rose(collision_heartbeat_pulse_o)
      |=> collision_heartbeat_pulse_o[*8] ##1 collision_heartbeat_pulse_o
      ##1 !collision_heartbeat_pulse_o)
      else $error("heartbeat length wrong");
   cover property (mgmt_rvalid_o && mgmt_rdata_o[8]);
   cover property ($fell(tx_enable_o) && tx_en_i);
   cover property ($rose(collision_heartbeat_pulse_o));
endmodule
bind tbcs_ctrl tbcs_ctrl_chk i_chk (.*);

// ---- sim/tbcs_mac_model.sv ----
`timescale 1ns/100ps
module tbcs_mac_model (
   input  wire logic       core_clk_i,
   input  wire logic       tx_req_i,
   output logic            tx_en_o,
   output logic      [3:0] txd_o
);
   logic req_q = 1'b0;
   // request taken on the rising edge so the falling-edge drive never races the bench
   always @(posedge core_clk_i) begin
      req_q <= tx_req_i;
   end
   // frame nibbles count up; idle lines toggle between the last nibble and its inverse
   initial begin
      tx_en_o = 1'b0;
      txd_o   = 4'h0;
      forever begin
         @(negedge core_clk_i);
         tx_en_o <= req_q;
         txd_o   <= req_q ? txd_o + 4'h1 : ~txd_o;
      end
   end
endmodule

// ---- sim/tb_ten_base_t_control_status_crs.sv ----
`timescale 1ns/100ps
module tb_ten_base_t_control_status_crs;
   import tbcs_pkg::*;
   logic        core_clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        soft_rst_i, mgmt_wr_i, mgmt_rd_i, half_duplex_operation_i, link_integrity_ok_i;
   logic        eof_error_evt_i, disconnect_evt_i, tx_req, tx_en_i, rx_dv_i, rx_dv_o, crs_o;
   logic        tx_enable_o, collision_heartbeat_pulse_o, link_pass_o, link_integrity_bypass_o;
   logic        mgmt_rvalid_o, seen;
   logic [1:0]  hardware_config_straps_i, speed_i, squelch_sel_o;
   logic [4:0]  mgmt_addr_i;
   logic [15:0] mgmt_wdata_i, mgmt_rdata_o;
   logic [3:0]  txd_i, rxd_i, rxd_o;
   int          err_count = 0;
   int          checked = 0;
   localparam logic [5:0] ROWS [9] = '{6'h0B, 6'h1B, 6'h2A, 6'h3A, 6'h05, 6'h14, 6'h25, 6'h34,
                                       6'h3D};
   always #50 core_clk_i = ~core_clk_i;
   tbcs_ctrl #(.JAB_LIMIT(20)) i_dut (.*);
   tbcs_mac_model i_mac (.core_clk_i(core_clk_i), .tx_req_i(tx_req), .tx_en_o(tx_en_i),
      .txd_o(txd_i));
   task automatic test_done();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr_reg(logic [4:0] a, logic [15:0] d);
      @(negedge core_clk_i);
      mgmt_addr_i = a;
      mgmt_wdata_i = d;
      mgmt_wr_i = 1'b1;
      @(negedge core_clk_i);
      mgmt_wr_i = 1'b0;
   endtask
   task automatic rd_reg(logic [4:0] a, logic [15:0] exp);
      @(negedge core_clk_i);
      mgmt_addr_i = a;
      mgmt_rd_i = 1'b1;
      @(negedge core_clk_i);
      mgmt_rd_i = 1'b0;
      chk("rvalid", 16'h0001, 16'(mgmt_rvalid_o));
      chk("rdata", exp, mgmt_rdata_o);
   endtask
   task automatic pulse_soft();
      @(negedge core_clk_i);
      soft_rst_i = 1'b1;
      @(negedge core_clk_i);
      soft_rst_i = 1'b0;
   endtask
   // heartbeat is not judged where exp_hb is all ones
   task automatic burst(int n, logic [15:0] ctl, logic [15:0] exp_tx, logic [15:0] exp_echo,
                        logic [15:0] exp_hb);
      wr_reg(REG_LEGACY, ctl);
      tx_req = 1'b1;
      repeat (3) @(negedge core_clk_i);
      chk("echo", exp_echo, 16'(rx_dv_o));
      chk("echo_rxd", exp_echo[0] ? 16'(txd_i) : 16'(rxd_i), 16'(rxd_o));
      repeat (n) @(negedge core_clk_i);
      chk("tx_enable", exp_tx, 16'(tx_enable_o));
      tx_req = 1'b0;
      seen = 1'b0;
      repeat (14) begin
         @(negedge core_clk_i);
         seen = seen | collision_heartbeat_pulse_o;
      end
      if (exp_hb != 16'hFFFF)
         chk("heartbeat", exp_hb, 16'(seen));
   endtask
   initial begin
      {soft_rst_i, mgmt_wr_i, mgmt_rd_i, half_duplex_operation_i, link_integrity_ok_i} = '0;
      {eof_error_evt_i, disconnect_evt_i, tx_req, rx_dv_i} = '0;
      hardware_config_straps_i = 2'h2;
      speed_i = SPEED_10;
      mgmt_addr_i = 5'h00;
      mgmt_wdata_i = 16'h0000;
      rxd_i = 4'h0;
      repeat (10) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rd_reg(REG_RSVD_A, RSVD_A_RESET);
      rd_reg(REG_LEGACY, 16'h1200);
      $display("test reset done");
      for (int i = 0; i < 9; i++) begin
         wr_reg(REG_LEGACY, 16'h0200 | (16'(ROWS[i][5:4]) << 1));
         speed_i = (i < 4) ? 2'(1 + i % 2) : 2'(i % 3);
         half_duplex_operation_i = ROWS[i][3];
         rx_dv_i = ROWS[i][2];
         tx_req = ROWS[i][1];
         rxd_i = 4'(i);
         repeat (3) @(negedge core_clk_i);
         chk("crs", 16'(ROWS[i][0]), 16'(crs_o));
         chk("rxd", 16'(i), 16'(rxd_o));
         tx_req = 1'b0;
      end
      rx_dv_i = 1'b0;
      $display("test crs rows done");
      wr_reg(REG_RSVD_A, 16'hFFFF);
      rd_reg(REG_RSVD_A, 16'h0000);
      wr_reg(REG_LEGACY, 16'hFFFF);
      rd_reg(REG_LEGACY, 16'hFE46);
      chk("link_pass", 16'h0001, 16'(link_pass_o));
      for (int c = 0; c < 4; c++) begin
         wr_reg(REG_LEGACY, 16'h0200 | (16'(c) << 10));
         repeat (2) @(negedge core_clk_i);
         chk("squelch", (c == 3) ? 16'h0000 : 16'(c), 16'(squelch_sel_o));
      end
      $display("test reserved and squelch done");
      wr_reg(REG_LEGACY, 16'hFE06);
      pulse_soft();
      rd_reg(REG_LEGACY, 16'hFE46);
      wr_reg(REG_LEGACY, 16'hFC06);
      pulse_soft();
      rd_reg(REG_LEGACY, 16'h1000);
      $display("test soft reset done");
      @(negedge core_clk_i);
      {eof_error_evt_i, disconnect_evt_i} = 2'h3;
      @(negedge core_clk_i);
      {eof_error_evt_i, disconnect_evt_i} = 2'h0;
      rd_reg(REG_LEGACY, 16'h1180);
      rd_reg(REG_LEGACY, 16'h1000);
      link_integrity_ok_i = 1'b1;
      rd_reg(REG_LEGACY, 16'h1040);
      link_integrity_ok_i = 1'b0;
      rd_reg(REG_LEGACY, 16'h1000);
      $display("test flags done");
      speed_i = SPEED_10;
      half_duplex_operation_i = 1'b1;
      burst(2, 16'h0200, 16'h0001, 16'h0001, 16'h0001);
      burst(30, 16'h0200, 16'h0000, 16'h0001, 16'hFFFF);
      burst(30, 16'h7200, 16'h0001, 16'h0000, 16'h0000);
      $display("test transmit done");
      wr_reg(REG_LEGACY, 16'h8200);
      repeat (2) @(negedge core_clk_i);
      chk("bypass", 16'h0001, 16'(link_integrity_bypass_o));
      hardware_config_straps_i = 2'h1;
      rst_i = 1'b1;
      @(negedge core_clk_i);
      chk("rdata_rst", 16'h0000, mgmt_rdata_o);
      chk("bypass_rst", 16'h0000, 16'(link_integrity_bypass_o));
      repeat (3) @(negedge core_clk_i);
      rst_i = 1'b0;
      repeat (2) @(negedge core_clk_i);
      rd_reg(REG_LEGACY, 16'h2200);
      $display("test mid-run reset done");
      test_done();
   end
   initial begin
      #500000;
      err_count++;
      test_done();
   end
endmodule
